// ### gmdc_ctrl.sv
// gmdc_ctrl: device control register with wishbone slave, link/duplex/speed
// resolution, master-request blocking and self-clearing mac reset.
// assumes phy link and duplex pins are asynchronous; master pending and aux power are
// synchronous to clk_i; nvm values are stable while rst_i is high.
// Behaviour
// - register answers at offsets 0x0 and 0x4
// - bit 0 selects half or full duplex
// - bit 2 blocks new host master requests
// - master active flag clears when blocked, idle
// - bit 5 uses self-detected speed instead
// - link up only with link permit
// - link permit resets to nvm wake enable
// - speed field 9:8, reset 1000 Mb/s
// - auto-speed detect ignores speed field
// - forced duplex or phy duplex at link rise
// - reset reloads power-on and nvm values, lasts about 1 us
// - bit 27 enables pause frame reception
// - bit 28 enables xon/xoff transmission
// - autonegotiation loads both pause enables
// - bit 30 inserts vlan tag on request
// - bit 30 strips vlan tag on receive
// - nvm supplies duplex, auto_speed_detect_en, permit, force
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module gmdc_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [gmdc_pkg::GMDC_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire gmdc_pkg::gmdc_nvm_t nvm_i,
  input wire gmdc_pkg::gmdc_phy_t phy_i,
  input wire logic speed_bypass_i,
  input wire logic aux_power_present_i,
  input wire logic master_req_i,
  input wire logic master_pending_i,
  input wire logic desc_vlan_request_i,
  output logic master_req_o,
  output logic host_master_active_flag_o,
  output logic insert_vlan_o,
  output gmdc_pkg::gmdc_mac_cfg_t mac_cfg_o
);
  import gmdc_pkg::*;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [2:0] lnk_sync;
    logic [2:0] dpx_sync;
    logic link_q;
    logic dpx_q;
    logic dpx_latched;
    logic [GMDC_CW-1:0] rst_cnt;
    logic ack;
    logic [31:0] rdata;
    logic master_req;
    logic active_flag;
    logic insert_vlan;
    gmdc_mac_cfg_t cfg;
  } gmdc_state_t;

  gmdc_state_t st_ff;
  gmdc_state_t nxt_st;

  // alias decode for the control register
  function automatic logic is_ctrl(input logic [GMDC_AW-1:0] a);
    is_ctrl = (a == GMDC_OFF_CTRL) || (a == GMDC_OFF_CTRL_ALIAS);
  endfunction : is_ctrl

  function automatic logic [31:0] merge_sel(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & GMDC_WR_MASK;
    merge_sel = (old_v & ~m) | (new_v & m);
  endfunction : merge_sel

  function automatic logic [31:0] ctrl_reset(input gmdc_nvm_t n);
    logic [31:0] v;
    v = GMDC_CTRL_RST;
    v[GMDC_B_FD] = n.full_duplex_select;
    v[GMDC_B_AUTO_SPEED_DETECT_EN] = n.auto_speed_detect_en;
    v[GMDC_B_FORCE_SPEED] = n.force_speed;
    v[GMDC_B_SLU] = n.pm_wake_nvm_en;
    ctrl_reset = v;
  endfunction : ctrl_reset

  logic wb_req;
  logic link_rise;
  logic [31:0] ctrl_w;
  logic [1:0] spd_sel;

  always_comb begin
    nxt_st = st_ff;
    wb_req = wb_cyc_i && wb_stb_i && !st_ff.ack;
    ctrl_w = st_ff.ctrl;
    spd_sel = phy_i.phy_speed;
    // pin inputs: three flops, change taken when stages 2 and 3 agree
    nxt_st.lnk_sync = {st_ff.lnk_sync[1:0], phy_i.link};
    nxt_st.dpx_sync = {st_ff.dpx_sync[1:0], phy_i.phy_duplex_ind};
    if (st_ff.lnk_sync[2] == st_ff.lnk_sync[1]) begin
      nxt_st.link_q = st_ff.lnk_sync[2];
    end
    if (st_ff.dpx_sync[2] == st_ff.dpx_sync[1]) begin
      nxt_st.dpx_q = st_ff.dpx_sync[2];
    end
    link_rise = (st_ff.lnk_sync[2] == st_ff.lnk_sync[1]) && st_ff.lnk_sync[2] && !st_ff.link_q;
    // sample phy duplex on link rise
    if (link_rise) begin
      nxt_st.dpx_latched = st_ff.dpx_q;
    end
    // bus slave: one wait state, ack for one cycle
    nxt_st.ack = wb_req;
    nxt_st.rdata = 32'h0;
    if (wb_req) begin
      if (is_ctrl(wb_adr_i)) begin
        nxt_st.rdata = st_ff.ctrl;
        if (wb_we_i) begin
          ctrl_w = merge_sel(st_ff.ctrl, wb_dat_i, wb_sel_i);
        end
      end else if (wb_adr_i == GMDC_OFF_LINK_STAT) begin
        nxt_st.rdata = {24'h0, st_ff.cfg.speed, st_ff.cfg.full_duplex,
                        st_ff.cfg.link_up, st_ff.dpx_latched, st_ff.link_q,
                        st_ff.active_flag, st_ff.cfg.mac_reset};
      end else begin
        nxt_st.rdata = GMDC_UNMAPPED;
      end
    end
    if (phy_i.autoneg_en && phy_i.neg_done) begin
      ctrl_w[GMDC_B_RX_PAUSE_EN] = phy_i.neg_rx_pause;
      ctrl_w[GMDC_B_TX_PAUSE_EN] = phy_i.neg_tx_pause;
    end
    // self-clearing reset, held for the hold time
    if (ctrl_w[GMDC_B_RST] && st_ff.rst_cnt == '0) begin
      nxt_st.rst_cnt = GMDC_RST_CNT;
    end else if (st_ff.rst_cnt != '0) begin
      nxt_st.rst_cnt = st_ff.rst_cnt - GMDC_CW'(1);
    end
    ctrl_w[GMDC_B_RST] = 1'b0;
    nxt_st.ctrl = ctrl_w;
    // reset returns control to power-on values, nvm fields reloaded
    if (st_ff.rst_cnt == GMDC_CW'(1)) begin
      nxt_st.ctrl = ctrl_reset(nvm_i);
      nxt_st.dpx_latched = 1'b0;
    end
    if (st_ff.ctrl[GMDC_B_AUTO_SPEED_DETECT_EN]) begin
      spd_sel = phy_i.detected_speed;
    end else if (speed_bypass_i) begin
      spd_sel = phy_i.phy_speed;
    end else if (st_ff.ctrl[GMDC_B_FORCE_SPEED]) begin
      spd_sel = st_ff.ctrl[GMDC_B_SPD_LO +: 2];
    end
    nxt_st.cfg.speed = spd_sel;
    nxt_st.cfg.full_duplex = st_ff.ctrl[GMDC_B_FORCE_DUPLEX] ? st_ff.ctrl[GMDC_B_FD]
                                                       : st_ff.dpx_latched;
    // only link up is gated by permit
    nxt_st.cfg.link_up = st_ff.ctrl[GMDC_B_SLU] && st_ff.link_q;
    nxt_st.cfg.rx_pause_en = st_ff.ctrl[GMDC_B_RX_PAUSE_EN];
    nxt_st.cfg.tx_pause_en = st_ff.ctrl[GMDC_B_TX_PAUSE_EN];
    nxt_st.cfg.vlan_strip_en = st_ff.ctrl[GMDC_B_VME];
    nxt_st.cfg.vlan_tag_en = st_ff.ctrl[GMDC_B_VME];
    nxt_st.insert_vlan = st_ff.ctrl[GMDC_B_VME] && desc_vlan_request_i;
    nxt_st.cfg.mac_reset = (st_ff.rst_cnt != '0);
    nxt_st.cfg.cold_wake_adv = st_ff.ctrl[GMDC_B_ADV] && aux_power_present_i;
    nxt_st.master_req = master_req_i && !st_ff.ctrl[GMDC_B_MBLOCK];
    nxt_st.active_flag = !(st_ff.ctrl[GMDC_B_MBLOCK] && !master_pending_i
                           && !st_ff.master_req);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
      st_ff.ctrl <= GMDC_CTRL_RST;
      st_ff.active_flag <= 1'b1;
      st_ff.rst_cnt <= GMDC_CW'(1);
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wb_ack_o = st_ff.ack;
  assign wb_dat_o = st_ff.rdata;
  assign master_req_o = st_ff.master_req;
  assign host_master_active_flag_o = st_ff.active_flag;
  assign insert_vlan_o = st_ff.insert_vlan;
  assign mac_cfg_o = st_ff.cfg;

  a_alias_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && is_ctrl(wb_adr_i))
    |=> (wb_ack_o && wb_dat_o == $past(st_ff.ctrl)))
    else $error("control read data mismatch");

  a_ack_timing: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("ack not given in time");

  a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");

  a_idle_data: assert property (@(posedge clk_i) disable iff (rst_i)
    !wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");

  a_write_lands: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && is_ctrl(wb_adr_i)
     && wb_sel_i[3] && st_ff.rst_cnt == '0)
    |=> st_ff.ctrl[GMDC_B_VME] == $past(wb_dat_i[GMDC_B_VME]))
    else $error("control write lost");

  a_unmapped_rd: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o && !is_ctrl(wb_adr_i)
     && wb_adr_i != GMDC_OFF_LINK_STAT)
    |=> wb_dat_o == GMDC_UNMAPPED)
    else $error("unmapped read not zero");

  a_block_req: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(st_ff.ctrl[GMDC_B_MBLOCK]) |-> !master_req_o)
    else $error("master request while blocked");

  a_req_pass: assert property (@(posedge clk_i) disable iff (rst_i)
    (!st_ff.ctrl[GMDC_B_MBLOCK] && master_req_i) |=> master_req_o)
    else $error("master request dropped");

  // flag low when blocked and idle
  a_active_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff.ctrl[GMDC_B_MBLOCK] && !master_pending_i && !master_req_o)
    |=> !host_master_active_flag_o)
    else $error("active flag not cleared");

  a_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
    (master_pending_i || !st_ff.ctrl[GMDC_B_MBLOCK]) |=> host_master_active_flag_o)
    else $error("active flag not set");

  a_link_permit: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(st_ff.ctrl[GMDC_B_SLU]) |-> !mac_cfg_o.link_up)
    else $error("link up without permit");

  a_link_up: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i)
    |-> mac_cfg_o.link_up == ($past(st_ff.ctrl[GMDC_B_SLU]) && $past(st_ff.link_q)))
    else $error("link up mismatch");

  a_spd_auto: assert property (@(posedge clk_i) disable iff (rst_i)
    ($past(st_ff.ctrl[GMDC_B_AUTO_SPEED_DETECT_EN]) && !$past(rst_i))
    |-> mac_cfg_o.speed == $past(phy_i.detected_speed))
    else $error("auto speed not used");

  a_spd_bypass: assert property (@(posedge clk_i) disable iff (rst_i)
    ($past(speed_bypass_i) && !$past(st_ff.ctrl[GMDC_B_AUTO_SPEED_DETECT_EN]) && !$past(rst_i))
    |-> mac_cfg_o.speed == $past(phy_i.phy_speed))
    else $error("speed bypass ignored");

  a_spd_force: assert property (@(posedge clk_i) disable iff (rst_i)
    ($past(st_ff.ctrl[GMDC_B_FORCE_SPEED]) && !$past(st_ff.ctrl[GMDC_B_AUTO_SPEED_DETECT_EN])
     && !$past(speed_bypass_i) && !$past(rst_i))
    |-> mac_cfg_o.speed == $past(st_ff.ctrl[GMDC_B_SPD_LO +: 2]))
    else $error("forced speed mismatch");

  a_rst_self_clr: assert property (@(posedge clk_i) disable iff (rst_i)
    !st_ff.ctrl[GMDC_B_RST])
    else $error("reset bit stuck");

  a_rst_count: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff.rst_cnt != '0) |=> st_ff.rst_cnt == $past(st_ff.rst_cnt) - GMDC_CW'(1))
    else $error("reset counter stalled");

  // reset pulse stays high for at least 8 cycles
  a_rst_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff.rst_cnt == '0 ##1 st_ff.rst_cnt != '0) |-> ##1 mac_cfg_o.mac_reset[*8])
    else $error("mac reset too short");

  a_nvm_reload: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff.rst_cnt == GMDC_CW'(1)) |=> st_ff.ctrl == $past(ctrl_reset(nvm_i)))
    else $error("nvm reload mismatch");

  a_pause_neg: assert property (@(posedge clk_i) disable iff (rst_i)
    (phy_i.autoneg_en && phy_i.neg_done && st_ff.rst_cnt != GMDC_CW'(1))
    |=> (st_ff.ctrl[GMDC_B_RX_PAUSE_EN] == $past(phy_i.neg_rx_pause)
         && st_ff.ctrl[GMDC_B_TX_PAUSE_EN] == $past(phy_i.neg_tx_pause)))
    else $error("negotiated pause not loaded");

  a_rx_pause: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) |-> mac_cfg_o.rx_pause_en == $past(st_ff.ctrl[GMDC_B_RX_PAUSE_EN]))
    else $error("rx pause mismatch");

  a_tx_pause: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) |-> mac_cfg_o.tx_pause_en == $past(st_ff.ctrl[GMDC_B_TX_PAUSE_EN]))
    else $error("tx pause mismatch");

  a_vlan_strip: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) |-> (mac_cfg_o.vlan_strip_en == $past(st_ff.ctrl[GMDC_B_VME])
                       && mac_cfg_o.vlan_tag_en == $past(st_ff.ctrl[GMDC_B_VME])))
    else $error("vlan mode mismatch");

  a_vlan_insert: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i)
    |-> insert_vlan_o == ($past(st_ff.ctrl[GMDC_B_VME]) && $past(desc_vlan_request_i)))
    else $error("vlan insertion mismatch");

  a_reserved: assert property (@(posedge clk_i) disable iff (rst_i)
    st_ff.ctrl[3] && st_ff.ctrl[19:13] == 7'h0 && !st_ff.ctrl[29])
    else $error("reserved bits changed");

  a_forced_dpx: assert property (@(posedge clk_i) disable iff (rst_i)
    ($past(st_ff.ctrl[GMDC_B_FORCE_DUPLEX]) && !$past(rst_i))
    |-> mac_cfg_o.full_duplex == $past(st_ff.ctrl[GMDC_B_FD]))
    else $error("forced duplex mismatch");

  a_dpx_latch: assert property (@(posedge clk_i) disable iff (rst_i)
    (!$past(st_ff.ctrl[GMDC_B_FORCE_DUPLEX]) && !$past(rst_i))
    |-> mac_cfg_o.full_duplex == $past(st_ff.dpx_latched))
    else $error("phy duplex not used");

  a_cold_wake: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(st_ff.ctrl[GMDC_B_ADV]) |-> !mac_cfg_o.cold_wake_adv)
    else $error("cold wake advertised");

  a_wake_aux: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) |-> mac_cfg_o.cold_wake_adv
                      == ($past(st_ff.ctrl[GMDC_B_ADV]) && $past(aux_power_present_i)))
    else $error("cold wake advertisement mismatch");
endmodule : gmdc_ctrl
`default_nettype wire

// ### gmdc_pkg.sv
// gmdc_pkg: register offsets, field positions, reset values and carrier types
// for the device control register bank.
// assumes a 32-bit classic wishbone slave on a 25 MHz core clock.
package gmdc_pkg;
  localparam int unsigned GMDC_AW = 20;
  localparam logic [19:0] GMDC_OFF_CTRL = 20'h00000;
  localparam logic [19:0] GMDC_OFF_CTRL_ALIAS = 20'h00004;
  localparam logic [19:0] GMDC_OFF_LINK_STAT = 20'h00100;
  localparam int unsigned GMDC_B_FD = 0;
  localparam int unsigned GMDC_B_RSV1 = 1;
  localparam int unsigned GMDC_B_MBLOCK = 2;
  localparam int unsigned GMDC_B_RSV3 = 3;
  localparam int unsigned GMDC_B_RSV4 = 4;
  localparam int unsigned GMDC_B_AUTO_SPEED_DETECT_EN = 5;
  localparam int unsigned GMDC_B_SLU = 6;
  localparam int unsigned GMDC_B_RSV7 = 7;
  localparam int unsigned GMDC_B_SPD_LO = 8;
  localparam int unsigned GMDC_B_RSV10 = 10;
  localparam int unsigned GMDC_B_FORCE_SPEED = 11;
  localparam int unsigned GMDC_B_FORCE_DUPLEX = 12;
  localparam int unsigned GMDC_B_ADV = 20;
  localparam int unsigned GMDC_B_RST = 26;
  localparam int unsigned GMDC_B_RX_PAUSE_EN = 27;
  localparam int unsigned GMDC_B_TX_PAUSE_EN = 28;
  localparam int unsigned GMDC_B_VME = 30;
  // writable bits: 0,1,2,4,5,6,7,8,9,10,11,12,20,26,27,28,30
  localparam logic [31:0] GMDC_WR_MASK = 32'h5c101ff7;
  localparam logic [31:0] GMDC_CTRL_RST = 32'h00100208;
  localparam logic [1:0] GMDC_SPD_10 = 2'h0;
  localparam logic [1:0] GMDC_SPD_100 = 2'h1;
  localparam logic [1:0] GMDC_SPD_1000 = 2'h2;
  localparam logic [1:0] GMDC_SPD_RESET = 2'h2;
  localparam logic [31:0] GMDC_UNMAPPED = 32'h00000000;
  // reset-hold time in ns and its cycle count at the core clock
  localparam int unsigned GMDC_CLK_NS = 40;
  localparam int unsigned GMDC_RST_HOLD_NS = 1000;
  localparam int unsigned GMDC_RST_CYC = GMDC_RST_HOLD_NS / GMDC_CLK_NS;
  localparam int unsigned GMDC_CW = 6;
  localparam logic [GMDC_CW-1:0] GMDC_RST_CNT = GMDC_CW'(GMDC_RST_CYC);

  // initial values read from nonvolatile memory
  typedef struct packed {
    logic full_duplex_select;
    logic auto_speed_detect_en;
    logic force_speed;
    logic pm_wake_nvm_en;
  } gmdc_nvm_t;

  // resolved mac configuration towards the datapath
  typedef struct packed {
    logic link_up;
    logic full_duplex;
    logic [1:0] speed;
    logic rx_pause_en;
    logic tx_pause_en;
    logic vlan_tag_en;
    logic vlan_strip_en;
    logic mac_reset;
    logic cold_wake_adv;
  } gmdc_mac_cfg_t;

  // indications from the internal phy and the negotiation logic
  typedef struct packed {
    logic link;
    logic phy_duplex_ind;
    logic [1:0] phy_speed;
    logic [1:0] detected_speed;
    logic autoneg_en;
    logic neg_done;
    logic neg_rx_pause;
    logic neg_tx_pause;
  } gmdc_phy_t;
endpackage : gmdc_pkg

// ### tb_top.sv
// tb_top: self-checking bench for the device control register bank.
// assumes gmdc_pkg is compiled first; drives every port of gmdc_ctrl.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import gmdc_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, bypass, aux, mreq, mpend, dvlan;
  logic [19:0] adr, ra;
  logic [3:0] sel, s;
  logic [31:0] dat, rdat, mdl, d, wb_dat_o;
  logic wb_ack_o, req_o, flag_o, insv_o;
  gmdc_mac_cfg_t cfg;
  gmdc_nvm_t nvm;
  gmdc_phy_t phy;
  int bad_count, tests_run;
  logic [31:0] vc[5] = '{32'h00100948, 32'h58100948, 32'h58101948, 32'h00001909, 32'h00100a48};
  logic [3:0] vi[5] = '{4'b0110, 4'b1010, 4'b0101, 4'b0100, 4'b0100};
  logic [9:0] ve[5] = '{10'h342, 10'h33d, 10'h25e, 10'h140, 10'h382};

  gmdc_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .nvm_i(nvm), .phy_i(phy), .speed_bypass_i(bypass), .aux_power_present_i(aux),
    .master_req_i(mreq), .master_pending_i(mpend), .desc_vlan_request_i(dvlan),
    .master_req_o(req_o), .host_master_active_flag_o(flag_o), .insert_vlan_o(insv_o),
    .mac_cfg_o(cfg));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // register value after a reload from nonvolatile memory
  function automatic logic [31:0] rl(input gmdc_nvm_t n);
    rl = GMDC_CTRL_RST;
    rl[GMDC_B_FD] = n.full_duplex_select;
    rl[GMDC_B_AUTO_SPEED_DETECT_EN] = n.auto_speed_detect_en;
    rl[GMDC_B_SLU] = n.pm_wake_nvm_en;
    rl[GMDC_B_FORCE_SPEED] = n.force_speed;
  endfunction : rl

  // byte-lane write into the stored word
  function automatic logic [31:0] wm(input logic [31:0] o, input logic [31:0] w,
                                     input logic [3:0] b);
    logic [31:0] m;
    m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}} & GMDC_WR_MASK;
    wm = ((o & ~m) | (w & m)) & ~32'h04000000 | 32'h00000008;
  endfunction : wm

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  // one classic cycle; read data is taken with ack
  task automatic wb(input logic w, input logic [19:0] a, input logic [3:0] b,
                    input logic [31:0] v, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= b;
    dat <= v;
    n = 0;
    // ack and data are read as they stand at the rising edge
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) chk("wb_ack", 32'(wb_ack_o), 32'h1);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic wr(input logic [19:0] a, input logic [31:0] v);
    logic [31:0] q;
    wb(1'b1, a, 4'hf, v, q);
  endtask : wr

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask : settle

  initial begin
    #(40 * 20000);
    chk("watchdog", 32'h0, 32'h1);
    results();
  end

  initial begin
    {cyc, stb, we, bypass, aux, mreq, mpend, dvlan} = '0;
    adr = '0;
    sel = '0;
    dat = '0;
    rst_i = 1'b1;
    nvm = '{1'b1, 1'b0, 1'b0, 1'b1};
    phy = '0;
    phy.phy_duplex_ind = 1'b1;
    phy.neg_done = 1'b1;
    phy.neg_tx_pause = 1'b1;
    bad_count = 0;
    tests_run = 0;
    void'($urandom(34485));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    wb(1'b0, GMDC_OFF_CTRL, 4'hf, 32'h0, rdat);
    chk("ctrl_reset", rdat, rl(nvm));
    wb(1'b0, GMDC_OFF_CTRL_ALIAS, 4'hf, 32'h0, rdat);
    chk("ctrl_alias", rdat, rl(nvm));
    $display("test reset done");
    mreq <= 1'b1;
    mpend <= 1'b1;
    wr(GMDC_OFF_CTRL, 32'h0010004c);
    settle(3);
    chk("master_req", 32'(req_o), 32'h0);
    chk("active_flag", 32'(flag_o), 32'h1);
    @(posedge clk_i);
    mpend <= 1'b0;
    settle(3);
    chk("active_flag", 32'(flag_o), 32'h0);
    wr(GMDC_OFF_CTRL, 32'h00100048);
    settle(3);
    chk("master_req", 32'(req_o), 32'h1);
    chk("active_flag", 32'(flag_o), 32'h1);
    @(posedge clk_i);
    phy.link <= 1'b1;
    $display("test master block done");
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_i);
      {bypass, aux, dvlan, phy.autoneg_en} <= vi[i];
      wr(GMDC_OFF_CTRL, vc[i]);
      settle(8);
      chk("mac_cfg", 32'({cfg.link_up, cfg.full_duplex, cfg.speed, cfg.rx_pause_en,
        cfg.tx_pause_en, cfg.vlan_tag_en, cfg.vlan_strip_en, cfg.cold_wake_adv, insv_o}),
        32'(ve[i]));
    end
    $display("test mac config done");
    @(posedge clk_i);
    phy.autoneg_en <= 1'b0;
    mdl = 32'h00100008;
    wr(GMDC_OFF_CTRL, mdl);
    for (int i = 0; i < 24; i++) begin
      ra = $urandom_range(1, 0) ? GMDC_OFF_CTRL_ALIAS : GMDC_OFF_CTRL;
      s = 4'($urandom);
      // writable reserved bits, auto-speed detect and reset kept at zero
      d = $urandom & ~32'h040004b2;
      wb(1'b1, ra, s, d, rdat);
      mdl = wm(mdl, d, s);
      wb(1'b0, ra ^ 20'h4, 4'hf, 32'h0, rdat);
      chk("ctrl_rand", rdat, mdl);
    end
    $display("test random access done");
    wr(20'h00008, 32'hffffffff);
    wb(1'b0, 20'h00008, 4'hf, 32'h0, rdat);
    chk("unmapped", rdat, GMDC_UNMAPPED);
    wb(1'b0, GMDC_OFF_CTRL, 4'hf, 32'h0, rdat);
    chk("ctrl_kept", rdat, mdl);
    $display("test unmapped done");
    nvm <= '{1'b0, 1'b0, 1'b1, 1'b0};
    wr(GMDC_OFF_CTRL, mdl | 32'h04000000);
    settle(2);
    chk("mac_reset", 32'(cfg.mac_reset), 32'h1);
    settle(30);
    chk("mac_reset", 32'(cfg.mac_reset), 32'h0);
    wb(1'b0, GMDC_OFF_CTRL, 4'hf, 32'h0, rdat);
    chk("ctrl_reload", rdat, rl(nvm));
    $display("test soft reset done");
    results();
  end
endmodule : tb_top
`default_nettype wire
